// >>> design/scs_params.svh
// constants of the conversion channel sequencer: offsets, field positions, resets, counts
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define SCS_ADDR_CFG 12'h000
`define SCS_ADDR_CMD 12'h004
`define SCS_ADDR_STAT 12'h008

// ************************************************************
// configuration_word field positions and reset values
// ************************************************************
`define SCS_CFG_SEQ_BIT 11
`define SCS_CFG_CLK_BIT 10
`define SCS_CFG_TRIG_BIT 9
`define SCS_CFG_NAP_BIT 4
`define SCS_CFG_SEQ_RST 1'b1
`define SCS_CFG_CLK_RST 1'b1
`define SCS_CFG_TRIG_RST 1'b1
`define SCS_CFG_NAP_RST 1'b0

// ************************************************************
// command_word channel field
// ************************************************************
`define SCS_CMD_CH_LSB 0
`define SCS_CMD_CH_MSB 2
`define SCS_CH_RST 3'h0

// ************************************************************
// timing counts, in conversion clock cycles or pclk cycles
// ************************************************************
`define SCS_ACQ_CCLKS 5'h03
`define SCS_CONV_CCLKS 5'h12
`define SCS_CNT_ONE 5'h01
`define SCS_OSC_DIV 4'hb
`define SCS_OSC_ONE 4'h1

`endif

// >>> design/scs_pkg.sv
// types of the conversion channel sequencer
`default_nettype none
package scs_pkg;

    typedef enum logic [0:0] {
        scs_acq,
        scs_conv
    } scs_state_t;

    typedef struct packed {
        logic seq;       // channel_sequencing_bit: 1 automatic, 0 manual
        logic clk_int;   // 1 internal oscillator, 0 serial clock / 2
        logic trig_man;  // 1 manual trigger by convert_start_n, 0 automatic
        logic auto_nap;  // automatic nap enable, keeps oscillator alive
    } scs_cfg_t;

    typedef struct packed {
        logic converting;
        logic acq_ok;
        logic osc_run;
        logic [2:0] start_ch;
        logic [2:0] last_ch;
        logic [2:0] ptr;
    } scs_stat_t;

endpackage
`default_nettype wire

// >>> design/scs_seq.sv
// conversion clock, acquisition/conversion timing and channel sequencer with apb registers
//
// Notes on behaviour
// - conversion clock comes from the internal oscillator or the serial clock, by configuration.
// - internal oscillator runs only while converting or until three acquisition clocks have passed, unless auto trigger or auto nap.
// - with serial clock source each serial clock rise toggles the conversion clock.
// - acquisition lasts at least three conversion clocks before a conversion starts.
// - a conversion takes eighteen conversion clocks.
// - serial clock, manual trigger: done 36 serial clocks after the convert start fall.
// - during conversion the input is held and selected and common inputs disconnected.
// - four or eight channels by build parameter, sharing one common return.
// - clearing the channel sequencing bit selects manual channel selection.
// - setting the channel sequencing bit selects automatic selection; reset value.
// - first automatic conversion uses the channel last completed before entry.
// - sequencer steps up to the highest channel, then back to the start channel.
// - when starting at the highest channel only that channel is converted.
// - the multiplexer moves to the next channel ahead of its acquisition.
// - clearing the channel sequencing bit stops automatic stepping.
// - manual trigger: convert_start_n falling ends acquisition and starts conversion.
// - auto trigger: next conversion starts three clocks after the previous ends.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "scs_params.svh"
module scs_seq #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic pclk, // apb clock, 125 MHz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic [11:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic serial_clk, // serial clock pin from host
    input wire logic convert_start_n, // convert start pin, active low
    output logic [2:0] mux_sel, // selected input channel
    output logic sample_hold, // 1 hold, 0 sample
    output logic inputs_disconnect, // selected and common inputs cut off
    output logic osc_run, // internal oscillator enable
    output logic conv_done // one pclk pulse at end of conversion
);

    localparam logic [2:0] HI_CH = 3'(NUM_CH - 1);
    // ************************************************************
    // state
    // ************************************************************
    scs_pkg::scs_cfg_t cfg_q, cfg_d;
    scs_pkg::scs_state_t state_q, state_d;
    logic [2:0] ptr_q, ptr_d;
    logic [2:0] start_q, start_d;
    logic [2:0] last_q, last_d;
    logic [4:0] acq_cnt_q, acq_cnt_d;
    logic [4:0] conv_cnt_q, conv_cnt_d;
    logic [3:0] osc_cnt_q, osc_cnt_d;
    logic phase_q, phase_d;
    logic done_q, done_d;
    logic [31:0] prdata_q, prdata_d;
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic sclk_rise, convert_start_n_fall, acq_ok, osc_on, osc_tick, ser_tick, conversion_clock_tick;
    logic start_conv, end_conv, apb_wr, addr_ok, seq_enter;
    logic [2:0] last_now;
    scs_pkg::scs_cfg_t cfg_w;
    scs_pkg::scs_stat_t stat;
    // next channel of the automatic sweep
    function automatic logic [2:0] scs_next_ch(input logic [2:0] cur, input logic [2:0] first);
        scs_next_ch = (cur >= HI_CH) ? first : cur + 3'h1;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            sclk_s1_q <= serial_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q <= convert_start_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // ************************************************************
    // conversion clock
    // ************************************************************
    always_comb begin
        sclk_rise = sclk_s2_q & ~sclk_s3_q;
        convert_start_n_fall = ~cs_s2_q & cs_s3_q;
        acq_ok = acq_cnt_q >= `SCS_ACQ_CCLKS;
        // acquisition timing also needs the oscillator until three clocks have passed
        osc_on = cfg_q.clk_int & ((state_q == scs_pkg::scs_conv) | ~acq_ok
                 | ~cfg_q.trig_man | cfg_q.auto_nap);
        osc_tick = osc_on && (osc_cnt_q == `SCS_OSC_DIV - `SCS_OSC_ONE);
        ser_tick = ~cfg_q.clk_int & sclk_rise & phase_q;
        conversion_clock_tick = cfg_q.clk_int ? osc_tick : ser_tick;
        osc_cnt_d = (!osc_on || osc_tick) ? 4'h0 : osc_cnt_q + `SCS_OSC_ONE;
        phase_d = phase_q;
        if (start_conv) begin
            phase_d = 1'b0;
        end else if (~cfg_q.clk_int & sclk_rise) begin
            phase_d = ~phase_q;
        end
    end

    // ************************************************************
    // acquisition and conversion sequence
    // ************************************************************
    always_comb begin
        start_conv = (state_q == scs_pkg::scs_acq) && (cfg_q.trig_man
                     ? acq_ok && convert_start_n_fall
                     : acq_ok || (conversion_clock_tick && acq_cnt_q == `SCS_ACQ_CCLKS - `SCS_CNT_ONE));
        end_conv = (state_q == scs_pkg::scs_conv) && conversion_clock_tick
                   && (conv_cnt_q == `SCS_CONV_CCLKS - `SCS_CNT_ONE);
        state_d = state_q;
        acq_cnt_d = acq_cnt_q;
        conv_cnt_d = conv_cnt_q;
        done_d = end_conv;
        case (state_q)
            scs_pkg::scs_acq: begin
                if (start_conv) begin
                    state_d = scs_pkg::scs_conv;
                    conv_cnt_d = 5'h00;
                end else if (apb_wr && paddr == `SCS_ADDR_CMD && !cfg_q.seq) begin
                    acq_cnt_d = 5'h00;
                end else if (conversion_clock_tick && !acq_ok) begin
                    acq_cnt_d = acq_cnt_q + `SCS_CNT_ONE;
                end
            end
            scs_pkg::scs_conv: begin
                if (end_conv) begin
                    state_d = scs_pkg::scs_acq;
                    acq_cnt_d = 5'h00;
                end else if (conversion_clock_tick) begin
                    conv_cnt_d = conv_cnt_q + `SCS_CNT_ONE;
                end
            end
            default: begin
                state_d = scs_pkg::scs_acq;
            end
        endcase
    end

    // ************************************************************
    // channel pointer and sequencer
    // ************************************************************
    always_comb begin
        cfg_w.seq = pwdata[`SCS_CFG_SEQ_BIT];
        cfg_w.clk_int = pwdata[`SCS_CFG_CLK_BIT];
        cfg_w.trig_man = pwdata[`SCS_CFG_TRIG_BIT];
        cfg_w.auto_nap = pwdata[`SCS_CFG_NAP_BIT];
        cfg_d = cfg_q;
        if (apb_wr && paddr == `SCS_ADDR_CFG) begin
            cfg_d = cfg_w;
        end
        seq_enter = cfg_d.seq & ~cfg_q.seq;
        last_now = end_conv ? ptr_q : last_q;
        last_d = last_now;
        ptr_d = ptr_q;
        start_d = start_q;
        if (seq_enter) begin
            ptr_d = last_now;
            start_d = last_now;
        end else if (end_conv && cfg_q.seq) begin
            ptr_d = scs_next_ch(ptr_q, start_q);
        end else if (apb_wr && paddr == `SCS_ADDR_CMD && !cfg_q.seq) begin
            ptr_d = pwdata[`SCS_CMD_CH_MSB:`SCS_CMD_CH_LSB] & HI_CH;
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    always_comb begin
        apb_wr = psel & penable & pwrite;
        addr_ok = (paddr == `SCS_ADDR_CFG) || (paddr == `SCS_ADDR_CMD)
                  || (paddr == `SCS_ADDR_STAT);
        stat.converting = state_q == scs_pkg::scs_conv;
        stat.acq_ok = acq_ok;
        stat.osc_run = osc_on;
        stat.start_ch = start_q;
        stat.last_ch = last_q;
        stat.ptr = ptr_q;
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite) begin
            prdata_d = 32'h0000_0000;
            if (paddr == `SCS_ADDR_CFG) begin
                prdata_d[`SCS_CFG_SEQ_BIT] = cfg_q.seq;
                prdata_d[`SCS_CFG_CLK_BIT] = cfg_q.clk_int;
                prdata_d[`SCS_CFG_TRIG_BIT] = cfg_q.trig_man;
                prdata_d[`SCS_CFG_NAP_BIT] = cfg_q.auto_nap;
            end else if (paddr == `SCS_ADDR_CMD) begin
                prdata_d[`SCS_CMD_CH_MSB:`SCS_CMD_CH_LSB] = ptr_q;
            end else if (paddr == `SCS_ADDR_STAT) begin
                prdata_d = 32'(stat);
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.seq <= `SCS_CFG_SEQ_RST;
            cfg_q.clk_int <= `SCS_CFG_CLK_RST;
            cfg_q.trig_man <= `SCS_CFG_TRIG_RST;
            cfg_q.auto_nap <= `SCS_CFG_NAP_RST;
            state_q <= scs_pkg::scs_acq;
            ptr_q <= `SCS_CH_RST;
            start_q <= `SCS_CH_RST;
            last_q <= `SCS_CH_RST;
            acq_cnt_q <= 5'h00;
            conv_cnt_q <= 5'h00;
            osc_cnt_q <= 4'h0;
            phase_q <= 1'b0;
            done_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            state_q <= state_d;
            ptr_q <= ptr_d;
            start_q <= start_d;
            last_q <= last_d;
            acq_cnt_q <= acq_cnt_d;
            conv_cnt_q <= conv_cnt_d;
            osc_cnt_q <= osc_cnt_d;
            phase_q <= phase_d;
            done_q <= done_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign mux_sel = ptr_q;
    assign sample_hold = state_q == scs_pkg::scs_conv;
    assign inputs_disconnect = state_q == scs_pkg::scs_conv;
    assign osc_run = osc_on;
    assign conv_done = done_q;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_hold_in_conv;
        @(posedge pclk) disable iff (!presetn)
        $rose(state_q == scs_pkg::scs_conv) |-> sample_hold && inputs_disconnect
            throughout (state_q == scs_pkg::scs_conv) [*2];
    endproperty
    a_hold_in_conv: assert property (p_hold_in_conv)
        else $error("input not held while converting");

    property p_conv_len;
        @(posedge pclk) disable iff (!presetn)
        end_conv |-> conv_cnt_q == `SCS_CONV_CCLKS - `SCS_CNT_ONE
            ##1 conv_done && state_q == scs_pkg::scs_acq;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    property p_acq_min;
        @(posedge pclk) disable iff (!presetn)
        $rose(state_q == scs_pkg::scs_conv) |-> $past(acq_cnt_q) >= `SCS_ACQ_CCLKS
            || ($past(acq_cnt_q) == `SCS_ACQ_CCLKS - `SCS_CNT_ONE && $past(conversion_clock_tick));
    endproperty
    a_acq_min: assert property (p_acq_min)
        else $error("conversion started before acquisition time");
    property p_manual_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == scs_pkg::scs_acq && acq_ok && cfg_q.trig_man && convert_start_n_fall)
            |=> state_q == scs_pkg::scs_conv;
    endproperty
    a_manual_start: assert property (p_manual_start)
        else $error("convert start fall did not start conversion");
    property p_auto_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == scs_pkg::scs_acq && !cfg_q.trig_man && (acq_ok
            || (conversion_clock_tick && acq_cnt_q == `SCS_ACQ_CCLKS - `SCS_CNT_ONE)))
            |=> state_q == scs_pkg::scs_conv && conv_cnt_q == 5'h00;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("auto trigger did not start after three clocks");
    property p_seq_step;
        @(posedge pclk) disable iff (!presetn)
        (end_conv && cfg_q.seq && cfg_d.seq && ptr_q != HI_CH) |=> ptr_q == $past(ptr_q) + 3'h1;
    endproperty
    a_seq_step: assert property (p_seq_step)
        else $error("sequencer did not step");

    property p_seq_wrap;
        @(posedge pclk) disable iff (!presetn)
        (end_conv && cfg_q.seq && cfg_d.seq && ptr_q == HI_CH) |=> ptr_q == start_q;
    endproperty
    a_seq_wrap: assert property (p_seq_wrap)
        else $error("sequencer did not return to start channel");

    property p_manual_hold;
        @(posedge pclk) disable iff (!presetn)
        (end_conv && !cfg_q.seq && !cfg_d.seq) |=> $stable(ptr_q);
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("channel stepped in manual selection");

    property p_seq_entry;
        @(posedge pclk) disable iff (!presetn)
        (seq_enter && !end_conv) |=> ptr_q == $past(last_q) && start_q == $past(last_q);
    endproperty
    a_seq_entry: assert property (p_seq_entry)
        else $error("sequence did not start at last converted channel");

    property p_osc_gate;
        @(posedge pclk) disable iff (!presetn)
        (osc_run && cfg_q.trig_man && !cfg_q.auto_nap) |-> !acq_ok
            || state_q == scs_pkg::scs_conv;
    endproperty
    a_osc_gate: assert property (p_osc_gate)
        else $error("oscillator running while idle");

    property p_serial_div;
        @(posedge pclk) disable iff (!presetn)
        (!cfg_q.clk_int && sclk_rise && !start_conv) |=> phase_q != $past(phase_q);
    endproperty
    a_serial_div: assert property (p_serial_div)
        else $error("serial clock rise did not toggle conversion clock");

endmodule

`default_nettype wire

// >>> tb/scs_host_model.sv
// host controller model: serial clock and convert start pulses
`timescale 1ns/100ps
`default_nettype none
module scs_host_model (
    input wire logic pclk, // bench clock
    input wire logic presetn, // reset, active low
    input wire logic sclk_en, // run the serial clock
    input wire logic start_req, // one-cycle request for a convert start pulse
    output logic serial_clk, // serial clock, 4 pclk high then 4 low
    output logic convert_start_n // convert start, active low
);
    logic [2:0] ph_q;
    logic [2:0] low_q;
    logic pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 3'h0;
            low_q <= 3'h0;
            pend_q <= 1'b0;
            serial_clk <= 1'b0;
            convert_start_n <= 1'b1;
        end else begin
            ph_q <= sclk_en ? ph_q + 3'h1 : 3'h0;
            // clock stands low between frames
            serial_clk <= sclk_en & ~ph_q[2];
            if (start_req) begin
                pend_q <= 1'b1;
            end
            if (pend_q && low_q == 3'h0 && (ph_q == 3'h4 || !sclk_en)) begin
                // fall lands four pclk ahead of the next serial clock rise
                convert_start_n <= 1'b0;
                low_q <= 3'h6;
                pend_q <= 1'b0;
            end else if (low_q != 3'h0) begin
                low_q <= low_q - 3'h1;
                convert_start_n <= (low_q == 3'h1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the conversion channel sequencer
`timescale 1ns/100ps
`default_nettype none
`include "scs_params.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, sclk_en, start_req, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, serial_clk, convert_start_n;
    logic sample_hold, inputs_disconnect, osc_run, conv_done, osc_low;
    logic [2:0] mux_sel, ch_seen;
    int err_count, samples_checked, start_ch, cur, rises, k, p, t, h;

    scs_seq #(.NUM_CH(8)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clk(serial_clk), .convert_start_n(convert_start_n),
        .mux_sel(mux_sel), .sample_hold(sample_hold), .inputs_disconnect(inputs_disconnect),
        .osc_run(osc_run), .conv_done(conv_done));
    scs_host_model host_u (.pclk(pclk), .presetn(presetn), .sclk_en(sclk_en),
        .start_req(start_req), .serial_clk(serial_clk), .convert_start_n(convert_start_n));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic give_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        err_count++;
        $display("Error %s expected done seen timeout", what);
        give_verdict();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) timeout("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse_start;
        @(posedge pclk);
        start_req <= 1'b1;
        @(posedge pclk);
        start_req <= 1'b0;
    endtask

    // counts serial clock rises from the convert start fall to conv_done
    task automatic conv_once;
        int i;
        logic prev, got;
        repeat (60) @(posedge pclk);
        pulse_start();
        for (i = 0; i < 64; i++) begin
            @(negedge pclk);
            if (convert_start_n === 1'b0) break;
        end
        if (i == 64) timeout("convert start");
        prev = serial_clk;
        rises = 0;
        got = 1'b0;
        for (i = 0; i < 1000; i++) begin
            @(negedge pclk);
            if (serial_clk === 1'b1 && prev === 1'b0) rises++;
            prev = serial_clk;
            if (sample_hold === 1'b1 && !got) begin
                got = 1'b1;
                ch_seen = mux_sel;
                chk("inputs_disconnect", inputs_disconnect, 1);
            end
            if (conv_done === 1'b1) break;
        end
        if (i == 1000) timeout("conv_done");
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sclk_en = 1'b0;
        start_req = 1'b0;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'hf785));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("mux_sel reset", mux_sel, 0);
        chk("sample_hold reset", sample_hold, 0);
        apb(1'b0, `SCS_ADDR_CFG, 32'h0);
        chk("cfg reset", rd, 32'h0000_0e00);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped pslverr", er, 1);
        chk("unmapped prdata", rd, 0);
        $display("test reset done");

        apb(1'b1, `SCS_ADDR_CFG, 32'h0000_0200);
        sclk_en <= 1'b1;
        repeat (20) @(posedge pclk);
        @(negedge pclk);
        chk("osc_run idle", osc_run, 0);
        for (k = 0; k < 3; k++) begin
            start_ch = $urandom_range(7, 0);
            apb(1'b1, `SCS_ADDR_CMD, start_ch);
            pulse_start();
            repeat (30) @(negedge pclk);
            chk("early start", sample_hold, 0);
            conv_once();
            chk("serial rises", rises, 36);
            chk("manual channel", ch_seen, start_ch);
            apb(1'b0, `SCS_ADDR_CMD, 32'h0);
            chk("pointer", rd, start_ch);
        end
        $display("test manual done");

        for (p = 0; p < 2; p++) begin
            if (p == 1) begin
                start_ch = 7;
                apb(1'b1, `SCS_ADDR_CMD, 32'h7);
                conv_once();
            end
            apb(1'b1, `SCS_ADDR_CFG, 32'h0000_0a00);
            apb(1'b1, `SCS_ADDR_CMD, (start_ch + 1) % 8);
            cur = start_ch;
            for (k = 0; k < 10; k++) begin
                conv_once();
                chk("auto channel", ch_seen, cur);
                cur = (cur == 7) ? start_ch : cur + 1;
                repeat (2) @(negedge pclk);
                chk("mux ahead", mux_sel, cur);
            end
            apb(1'b1, `SCS_ADDR_CFG, 32'h0000_0200);
            repeat (2) begin
                conv_once();
                chk("stopped channel", ch_seen, cur);
            end
        end
        $display("test auto channel done");

        apb(1'b1, `SCS_ADDR_CFG, 32'h0000_0c00);
        sclk_en <= 1'b0;
        start_ch = cur;
        for (k = 0; k < 3; k++) begin
            t = 0;
            h = 0;
            osc_low = 1'b0;
            do begin
                @(negedge pclk);
                t++;
                if (sample_hold === 1'b1 && h == 0) ch_seen = mux_sel;
                if (sample_hold === 1'b1) h++;
                if (osc_run !== 1'b1) osc_low = 1'b1;
                if (t > 2000) timeout("auto trigger");
            end while (conv_done !== 1'b1);
            if (k > 0) begin
                chk("cycle length", t, 21 * `SCS_OSC_DIV);
                chk("hold length", h, 18 * `SCS_OSC_DIV);
                chk("osc_run auto", osc_low, 0);
                chk("auto trig channel", ch_seen, cur);
            end
            cur = (cur == 7) ? start_ch : cur + 1;
        end
        $display("test auto trigger done");
        give_verdict();
    end
endmodule
`default_nettype wire
